// file: multimode_timer_a_unit.sv
// multimode timer unit with AXI4-Lite register access
// Contract
// RULE1: every channel is stopped after reset and counts only once started
// RULE2: software changes mode, source, trigger, polarity only while stopped
// RULE3: trigger select 01b, 10b, 11b chains another timer's request
// RULE4: chained events use the raw request, regardless of any masking
// RULE5: cutoff enabled and shutdown low puts six phase pins high impedance (code releases three output pins, bits 1, 2 and 4, and raises phase_input_hiz)
// RULE6: timer mode read gives live count, or FFFFh during a reload
// RULE7: read while stopped returns the value that was written
// RULE8: event mode reload read gives FFFFh on underflow, 0000h on overflow
// RULE9: one-shot stop halts counting and loads the reload value
// RULE10: one-shot stop drives output to the polarity bit level
// RULE11: one-shot software stop sets request flag one clock later
// RULE12: one-shot output follows trigger, synchronised to count source
// RULE13: entering one-shot from timer or event mode sets the flag
// RULE14: retrigger while running decrements once, then reloads
// RULE15: trigger source spaces retriggers over one count source cycle
// RULE16: external source avoids retrigger 300 ns before count ends
// RULE17: entering PWM or programmable output from timer/event sets flag
// RULE18: PWM stop, polarity 0: high goes low and sets flag
// RULE19: PWM stop, polarity 1: low goes high and sets flag
// RULE20: programmable output stop goes inactive, flag unchanged
// RULE21: request flag stays set until software writes zero
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "tmra_cfg.svh"
module multimode_timer_a_unit #(
   parameter int NCH = 5
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [7:0]       awaddr,
   input  wire logic             awvalid,
   output var  logic             awready,
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output var  logic             wready,
   output var  logic [1:0]       bresp,
   output var  logic             bvalid,
   input  wire logic             bready,
   input  wire logic [7:0]       araddr,
   input  wire logic             arvalid,
   output var  logic             arready,
   output var  logic [31:0]      rdata,
   output var  logic [1:0]       rresp,
   output var  logic             rvalid,
   input  wire logic             rready,
   input  wire logic [NCH-1:0]   timer_input_pin,
   input  wire logic             shutdown_input_n,
   output var  logic [NCH-1:0]   timer_output_pin,
   output var  logic [NCH-1:0]   timer_output_pin_oe,
   output var  logic             phase_input_hiz
);
   if (NCH < 5 || NCH > 8) begin : g_bad_nch
      $error("NCH must lie between 5 and 8");
   end

   function automatic logic [7:0] ofs(input logic [7:0] b, input int i);
      ofs = b + 8'(4 * i);
   endfunction : ofs

   function automatic logic mapped(input logic [7:0] a);
      mapped = a == `TMR_START_OFS || a == `TMR_POL_OFS ||
               a == `TMR_FLAG_OFS || a == `TMR_CUT_OFS;
      for (int i = 0; i < NCH; i++) begin
         if (a == ofs(`TMR_MODE_BASE, i) || a == ofs(`TMR_CNT_BASE, i))
            mapped = 1'b1;
      end
   endfunction : mapped

   function automatic logic [15:0] upd16(input logic [15:0] o,
         input logic [31:0] d, input logic [3:0] s);
      upd16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction : upd16

   function automatic int src(input int i, input logic [1:0] t);
      src = (i + NCH - int'(t)) % NCH;
   endfunction : src

   logic [7:0]          waddr_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic                do_wr;
   logic [NCH-1:0]      start_r, start_nxt, stopping, pol_r, flag_r;
   logic [NCH-1:0]      flag_set, flag_clr, out_r, raw_r, osstop_r;
   logic [NCH-1:0]      run_r, pend_r, rtg_r, up_r, tick, trg;
   logic [NCH-1:0]      modewr, cntwr, modeset, pwmstop;
   logic                cut_en_r;
   tmra_pkg::mode_e     mode_r [NCH];
   tmra_pkg::reload_e   rl_r [NCH];
   logic [1:0]          trig_r [NCH];
   logic [7:0]          pre_r [NCH];
   logic [7:0]          psc_r [NCH];
   logic [15:0]         cnt_r [NCH];
   logic [15:0]         rld_r [NCH];
   logic [NCH-1:0]      tin_a, tin_b, tin_c, tin_s, tin_agree, tin_rise;
   logic                shut_a, shut_b, shut_c, shut_s;
   logic [31:0]         rword;

   assign do_wr = !awready && !wready && !bvalid;

   // write side: address and data are taken in either order
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= `TMR_RESP_OKAY;
         waddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            waddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            wready  <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= mapped(waddr_r) ? `TMR_RESP_OKAY : `TMR_RESP_ERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   always_comb begin
      rword = 32'h0000_0000;
      if (araddr == `TMR_START_OFS) rword = 32'(start_r);
      if (araddr == `TMR_POL_OFS) rword = 32'(pol_r);
      if (araddr == `TMR_FLAG_OFS) rword = 32'(flag_r);
      if (araddr == `TMR_CUT_OFS) rword = 32'(cut_en_r);
      for (int i = 0; i < NCH; i++) begin
         if (araddr == ofs(`TMR_MODE_BASE, i))
            rword = {16'h0000, pre_r[i], 2'b00, up_r[i], trig_r[i],
                     mode_r[i]};
         // a read that meets a reload shows the wrap value
         if (araddr == ofs(`TMR_CNT_BASE, i)) begin // see RULE6 RULE8
            unique case (rl_r[i])
               tmra_pkg::RL_UNDER: rword = {16'h0000, `TMR_CNT_UFL};
               tmra_pkg::RL_OVER:  rword = {16'h0000, `TMR_CNT_OFL};
               tmra_pkg::RL_NONE:  rword = {16'h0000, cnt_r[i]};
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `TMR_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rword;
         rresp   <= mapped(araddr) ? `TMR_RESP_OKAY : `TMR_RESP_ERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // pins are asynchronous: three stages, accepted when the last two agree
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         {tin_a, tin_b, tin_c, tin_s} <= '0;
         {shut_a, shut_b, shut_c, shut_s} <= 4'hF;
      end else begin
         tin_a <= timer_input_pin;
         tin_b <= tin_a;
         tin_c <= tin_b;
         tin_s <= (tin_agree & tin_c) | (~tin_agree & tin_s);
         shut_a <= shutdown_input_n;
         shut_b <= shut_a;
         shut_c <= shut_b;
         if (shut_b == shut_c) shut_s <= shut_c;
      end
   end
   assign tin_agree = ~(tin_b ^ tin_c);
   assign tin_rise = tin_agree & tin_c & ~tin_s;

   always_comb begin
      start_nxt = start_r;
      flag_clr = '0;
      if (do_wr && wstrb_r[0] && waddr_r == `TMR_START_OFS)
         start_nxt = wdata_r[NCH-1:0];
      if (do_wr && wstrb_r[0] && waddr_r == `TMR_FLAG_OFS)
         flag_clr = ~wdata_r[NCH-1:0];
      for (int i = 0; i < NCH; i++) begin
         tick[i] = start_r[i] && psc_r[i] == 8'h00;
         trg[i] = trig_r[i] == 2'b00 ? tin_rise[i]
                                     : raw_r[src(i, trig_r[i])]; // see RULE3 RULE4
         modewr[i] = do_wr && wstrb_r[0] && waddr_r == ofs(`TMR_MODE_BASE, i);
         cntwr[i] = do_wr && waddr_r == ofs(`TMR_CNT_BASE, i);
         modeset[i] = modewr[i] && (mode_r[i] == tmra_pkg::M_TIMER ||
            mode_r[i] == tmra_pkg::M_EVENT) &&
            wdata_r[`TMR_MODE_LSB +: 3] inside {tmra_pkg::M_ONESHOT,
            tmra_pkg::M_PWM, tmra_pkg::M_PROG}; // see RULE13 RULE17
         pwmstop[i] = stopping[i] && mode_r[i] == tmra_pkg::M_PWM &&
                      out_r[i] != pol_r[i]; // see RULE18 RULE19
      end
   end
   assign stopping = start_r & ~start_nxt;
   assign flag_set = raw_r | osstop_r | pwmstop | modeset;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         start_r  <= '0; // see RULE1
         pol_r    <= '0;
         cut_en_r <= 1'b0;
         flag_r   <= '0;
      end else begin
         start_r <= start_nxt;
         if (do_wr && wstrb_r[0] && waddr_r == `TMR_POL_OFS)
            pol_r <= wdata_r[NCH-1:0];
         if (do_wr && wstrb_r[0] && waddr_r == `TMR_CUT_OFS)
            cut_en_r <= wdata_r[0];
         // a new request beats a clear in the same cycle
         flag_r <= (flag_r & ~flag_clr) | flag_set; // see RULE21
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (rst) begin
            mode_r[i] <= tmra_pkg::M_TIMER;
            trig_r[i] <= 2'b00;
            up_r[i]   <= 1'b0;
            pre_r[i]  <= 8'h00;
         end else if (modewr[i]) begin
            mode_r[i] <= tmra_pkg::mode_e'(wdata_r[`TMR_MODE_LSB +: 3]);
            trig_r[i] <= wdata_r[`TMR_TRIG_LSB +: 2];
            up_r[i]   <= wdata_r[`TMR_UP_BIT];
            if (wstrb_r[1]) pre_r[i] <= wdata_r[`TMR_PRE_LSB +: 8];
         end
      end
   end

   // channel engines; timer, one-shot and PWM act at count source ticks, event mode on each trigger
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (rst) begin
            cnt_r[i] <= `TMR_CNT_RST;
            rld_r[i] <= `TMR_CNT_RST;
            psc_r[i] <= 8'h00;
            rl_r[i]  <= tmra_pkg::RL_NONE;
            {out_r[i], raw_r[i], osstop_r[i]} <= 3'b000;
            {run_r[i], pend_r[i], rtg_r[i]} <= 3'b000;
         end else begin
            raw_r[i] <= 1'b0;
            osstop_r[i] <= 1'b0;
            rl_r[i] <= tmra_pkg::RL_NONE;
            if (cntwr[i]) begin
               rld_r[i] <= upd16(rld_r[i], wdata_r, wstrb_r);
               if (!start_r[i])
                  cnt_r[i] <= upd16(cnt_r[i], wdata_r, wstrb_r); // see RULE7
            end
            if (!start_r[i] || stopping[i]) begin
               psc_r[i] <= pre_r[i];
               {run_r[i], pend_r[i], rtg_r[i]} <= 3'b000;
            end else begin
               psc_r[i] <= tick[i] ? pre_r[i] : psc_r[i] - 8'h01;
            end
            if (stopping[i]) begin
               unique case (mode_r[i])
                  tmra_pkg::M_ONESHOT: begin
                     cnt_r[i] <= rld_r[i]; // see RULE9
                     out_r[i] <= pol_r[i]; // see RULE10
                     osstop_r[i] <= 1'b1; // see RULE11
                  end
                  tmra_pkg::M_PWM, tmra_pkg::M_PROG:
                     out_r[i] <= pol_r[i]; // see RULE18 RULE19 RULE20
                  default: ;
               endcase
            end else if (start_r[i]) begin // see RULE1
               unique case (mode_r[i])
                  tmra_pkg::M_TIMER, tmra_pkg::M_PROG: begin
                     if (tick[i] && cnt_r[i] == 16'h0000) begin
                        cnt_r[i] <= rld_r[i];
                        raw_r[i] <= 1'b1;
                        rl_r[i]  <= tmra_pkg::RL_UNDER;
                        if (mode_r[i] == tmra_pkg::M_PROG)
                           out_r[i] <= ~out_r[i];
                     end else if (tick[i]) begin
                        cnt_r[i] <= cnt_r[i] - 16'h0001;
                     end
                  end
                  tmra_pkg::M_EVENT: begin
                     if (trg[i] && up_r[i] && cnt_r[i] == 16'hFFFF) begin
                        cnt_r[i] <= rld_r[i];
                        raw_r[i] <= 1'b1;
                        rl_r[i]  <= tmra_pkg::RL_OVER;
                     end else if (trg[i] && !up_r[i] &&
                                  cnt_r[i] == 16'h0000) begin
                        cnt_r[i] <= rld_r[i];
                        raw_r[i] <= 1'b1;
                        rl_r[i]  <= tmra_pkg::RL_UNDER;
                     end else if (trg[i]) begin
                        cnt_r[i] <= up_r[i] ? cnt_r[i] + 16'h0001
                                            : cnt_r[i] - 16'h0001;
                     end
                  end
                  tmra_pkg::M_ONESHOT: begin
                     // triggers wait for a tick, so output is count aligned
                     if (tick[i]) begin // see RULE12
                        pend_r[i] <= 1'b0;
                        if (!run_r[i]) begin
                           if (pend_r[i]) begin
                              run_r[i] <= 1'b1;
                              out_r[i] <= ~pol_r[i];
                              cnt_r[i] <= rld_r[i];
                           end
                        end else if (rtg_r[i]) begin
                           rtg_r[i] <= 1'b0;
                           cnt_r[i] <= rld_r[i]; // see RULE14
                        end else if (cnt_r[i] == 16'h0000) begin
                           run_r[i] <= 1'b0;
                           out_r[i] <= pol_r[i];
                           raw_r[i] <= 1'b1;
                           rl_r[i]  <= tmra_pkg::RL_UNDER;
                           cnt_r[i] <= rld_r[i];
                        end else begin
                           cnt_r[i] <= cnt_r[i] - 16'h0001;
                           if (pend_r[i]) rtg_r[i] <= 1'b1; // see RULE14
                        end
                     end
                     if (trg[i]) pend_r[i] <= 1'b1;
                  end
                  tmra_pkg::M_PWM: begin
                     // low byte is period less one, high byte active width
                     if (tick[i]) begin
                        out_r[i] <= (cnt_r[i][7:0] < rld_r[i][15:8]) ^
                                    pol_r[i];
                        if (cnt_r[i] == 16'h0000) begin
                           cnt_r[i] <= {8'h00, rld_r[i][7:0]};
                           raw_r[i] <= 1'b1;
                        end else begin
                           cnt_r[i] <= cnt_r[i] - 16'h0001;
                        end
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timer_output_pin    <= '0;
         timer_output_pin_oe <= '1;
         phase_input_hiz     <= 1'b0;
      end else begin
         timer_output_pin    <= out_r;
         timer_output_pin_oe <= ~(NCH'(`TMR_PHASE_MASK) &
                                 {NCH{cut_en_r && !shut_s}}); // see RULE5
         phase_input_hiz     <= cut_en_r && !shut_s; // see RULE5
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_chk
      a_stop_cnt_hold: assert property (@(posedge sys_clk) disable iff (rst) // see RULE1
         !start_r[g] && !do_wr |=> $stable(cnt_r[g]))
         else $error("stopped counter moved");
      a_chain_event_count: assert property (@(posedge sys_clk) disable iff (rst) // see RULE3
         start_r[g] && !do_wr && mode_r[g] == tmra_pkg::M_EVENT &&
         trig_r[g] != 2'b00 && raw_r[src(g, trig_r[g])] |=>
         cnt_r[g] != $past(cnt_r[g]) || rl_r[g] != tmra_pkg::RL_NONE)
         else $error("chained event not counted");
      a_rd_reload_ffff: assert property (@(posedge sys_clk) disable iff (rst) // see RULE6
         arvalid && arready && araddr == ofs(`TMR_CNT_BASE, g) &&
         rl_r[g] == tmra_pkg::RL_UNDER |=> rdata == 32'h0000_FFFF)
         else $error("reload read not FFFFh");
      a_wr_stopped_cnt: assert property (@(posedge sys_clk) disable iff (rst) // see RULE7
         cntwr[g] && !start_r[g] && wstrb_r[1:0] == 2'b11 |=>
         cnt_r[g] == $past(wdata_r[15:0]))
         else $error("stopped write not in counter");
      a_os_stop_out: assert property (@(posedge sys_clk) disable iff (rst) // see RULE10
         $fell(start_r[g]) && mode_r[g] == tmra_pkg::M_ONESHOT |->
         out_r[g] == pol_r[g] && cnt_r[g] == rld_r[g])
         else $error("one-shot stop output or reload wrong");
      a_os_stop_flag: assert property (@(posedge sys_clk) disable iff (rst) // see RULE11
         $fell(start_r[g]) && mode_r[g] == tmra_pkg::M_ONESHOT |->
         ##1 flag_r[g])
         else $error("one-shot stop flag not set");
      a_mode_flag_set: assert property (@(posedge sys_clk) disable iff (rst) // see RULE13
         modeset[g] |=> flag_r[g])
         else $error("mode change did not set flag");
      a_pwm_stop_level: assert property (@(posedge sys_clk) disable iff (rst) // see RULE18
         $fell(start_r[g]) && mode_r[g] == tmra_pkg::M_PWM &&
         $past(out_r[g]) != pol_r[g] |-> out_r[g] == pol_r[g] && flag_r[g])
         else $error("pwm stop level or flag wrong");
      a_prog_stop_level: assert property (@(posedge sys_clk) disable iff (rst) // see RULE20
         $fell(start_r[g]) && mode_r[g] == tmra_pkg::M_PROG |->
         out_r[g] == pol_r[g])
         else $error("programmable output stop level wrong");
      a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst) // see RULE21
         flag_r[g] && !flag_clr[g] |=> flag_r[g])
         else $error("flag dropped without clear");
   end
endmodule : multimode_timer_a_unit
`default_nettype wire

// file: tmra_cfg.svh
// register offsets, field positions and reset values of the timer unit
`ifndef TMRA_CFG_SVH
`define TMRA_CFG_SVH
`define TMR_START_OFS  8'h00
`define TMR_POL_OFS    8'h04
`define TMR_FLAG_OFS   8'h08
`define TMR_CUT_OFS    8'h0C
`define TMR_MODE_BASE  8'h20
`define TMR_CNT_BASE   8'h40
`define TMR_MODE_LSB   0
`define TMR_TRIG_LSB   3
`define TMR_UP_BIT     5
`define TMR_PRE_LSB    8
`define TMR_CNT_RST    16'h0000
`define TMR_CNT_UFL    16'hFFFF
`define TMR_CNT_OFL    16'h0000
`define TMR_PHASE_MASK 8'h16
`define TMR_RESP_OKAY  2'h0
`define TMR_RESP_ERR   2'h2
`endif

// file: tmra_pkg.sv
// types shared by the timer unit
`default_nettype none
package tmra_pkg;
   typedef enum logic [2:0] {M_TIMER, M_EVENT, M_ONESHOT, M_PWM, M_PROG}
      mode_e;
   typedef enum logic [1:0] {RL_NONE, RL_UNDER, RL_OVER} reload_e;
endpackage : tmra_pkg
`default_nettype wire

// file: pin_side_model.sv
// pin-side model: trigger pins, shutdown level and resolved output wires
`timescale 1ns/1ps
`default_nettype none
module pin_side_model #(
   parameter int NCH = 5
) (
   input  wire logic           sys_clk,
   input  wire logic [NCH-1:0] fire,
   input  wire logic           shut_low,
   input  wire logic [NCH-1:0] out_lvl,
   input  wire logic [NCH-1:0] out_oe,
   output var  logic [NCH-1:0] timer_input_pin,
   output var  logic           shutdown_input_n,
   output var  logic [NCH-1:0] pin_level
);
   logic [NCH-1:0] last_r;
   // pulses are spaced by the bench, never close to a count end
   assign timer_input_pin = fire;
   assign shutdown_input_n = !shut_low;
   always_ff @(posedge sys_clk) begin
      last_r <= (out_oe & out_lvl) | (~out_oe & last_r);
   end
   // a released wire must not keep showing its last driven level
   assign pin_level = (out_oe & out_lvl) | (~out_oe & ~last_r);
endmodule : pin_side_model
`default_nettype wire

// file: test_multimode_timer_a_unit.sv
// register-level testbench of the multimode timer unit
`timescale 1ns/1ps
`default_nettype none
`include "tmra_cfg.svh"
module test_multimode_timer_a_unit;
   logic        sys_clk;
   logic        rst;
   logic [7:0]  awaddr;
   logic [7:0]  araddr;
   logic        awvalid;
   logic        wvalid;
   logic        bready;
   logic        arvalid;
   logic        rready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic [4:0]  fire;
   logic        shut_low;
   logic        hit;
   logic [31:0] rd;
   logic [1:0]  rs;
   int          miscompares;
   int          tests_run;
   wire logic        awready, wready, bvalid, arready, rvalid;
   wire logic        shutdown_input_n, phase_input_hiz;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [4:0]  timer_input_pin, timer_output_pin;
   wire logic [4:0]  timer_output_pin_oe, pin_lvl;

   multimode_timer_a_unit #(.NCH(5)) dut (
      .sys_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .timer_input_pin,
      .shutdown_input_n, .timer_output_pin, .timer_output_pin_oe,
      .phase_input_hiz
   );
   pin_side_model #(.NCH(5)) pins (
      .sys_clk, .fire, .shut_low, .out_lvl(timer_output_pin),
      .out_oe(timer_output_pin_oe), .timer_input_pin,
      .shutdown_input_n, .pin_level(pin_lvl)
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   task automatic endt(input string nm);
      $display("test %s done", nm);
   endtask : endt

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd = rdata;
            rs = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : rdr

   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      fire = 5'h0;
      shut_low = 1'b0;
      cyc(8);
      rst <= 1'b0;
      rdr(`TMR_START_OFS);
      chk("start", rd, 32'h0);
      rdr(`TMR_CNT_BASE);
      chk("cnt0", rd, {16'h0, `TMR_CNT_RST});
      chk("oe", {27'h0, timer_output_pin_oe}, 32'h1F);
      rdr(8'hFC);
      chk("rd err", {30'h0, rs}, {30'h0, `TMR_RESP_ERR});
      chk("rd err data", rd, 32'h0);
      wr(8'hF0, 32'h0);
      chk("wr err", {30'h0, rs}, {30'h0, `TMR_RESP_ERR});
      wr(`TMR_CNT_BASE + 8'h0C, 32'h0000_1234);
      rdr(`TMR_CNT_BASE + 8'h0C);
      chk("stopped cnt", rd, 32'h0000_1234);
      endt("reset");
      // every setup below is written while the channel is stopped
      wr(`TMR_CNT_BASE, 32'h0000_0003);
      wr(`TMR_MODE_BASE + 8'h04, 32'h0000_0009);
      wr(`TMR_CNT_BASE + 8'h04, 32'h0000_03E8);
      wr(`TMR_START_OFS, 32'h0000_0003);
      cyc(40);
      // reads three cycles apart meet every phase of the 4-cycle period
      hit = 1'b0;
      repeat (4) begin
         rdr(`TMR_CNT_BASE);
         if (rd == 32'h0000_FFFF) hit = 1'b1;
      end
      chk("reload read", {31'h0, hit}, 32'h1);
      rdr(`TMR_CNT_BASE + 8'h04);
      chk("chained", {31'h0, rd < 1000 && rd > 900}, 32'h1);
      wr(`TMR_START_OFS, 32'h0);
      rdr(`TMR_FLAG_OFS);
      chk("held flag", {30'h0, rd[1:0]}, 32'h1);
      wr(`TMR_FLAG_OFS, 32'h0);
      rdr(`TMR_FLAG_OFS);
      chk("cleared", rd, 32'h0);
      endt("chain");
      wr(`TMR_POL_OFS, 32'h0000_000C);
      wr(`TMR_MODE_BASE + 8'h04, 32'h0000_0003);
      wr(`TMR_MODE_BASE + 8'h0C, 32'h0000_0004);
      rdr(`TMR_FLAG_OFS);
      chk("entry flags", rd, 32'h0000_000A);
      wr(`TMR_FLAG_OFS, 32'h0);
      wr(`TMR_START_OFS, 32'h0000_0008);
      cyc(20);
      wr(`TMR_START_OFS, 32'h0);
      cyc(4);
      rdr(`TMR_FLAG_OFS);
      chk("prog flag", rd, 32'h0);
      chk("prog out", {31'h0, timer_output_pin[3]}, 32'h1);
      endt("progout");
      // full width keeps the output active until the stop lands
      wr(`TMR_CNT_BASE + 8'h04, 32'h0000_FF04);
      wr(`TMR_START_OFS, 32'h0000_0002);
      wr(`TMR_START_OFS, 32'h0);
      rdr(`TMR_FLAG_OFS);
      chk("pwm stop flag", rd, 32'h0000_0002);
      chk("pwm stop out", {31'h0, timer_output_pin[1]}, 32'h0);
      wr(`TMR_FLAG_OFS, 32'h0);
      endt("pwm");
      wr(`TMR_MODE_BASE + 8'h08, 32'h0000_0002);
      rdr(`TMR_FLAG_OFS);
      chk("oneshot entry", rd, 32'h0000_0004);
      wr(`TMR_FLAG_OFS, 32'h0);
      wr(`TMR_CNT_BASE + 8'h08, 32'h0000_0064);
      wr(`TMR_START_OFS, 32'h0000_0004);
      cyc(4);
      fire <= 5'h04;
      cyc(4);
      fire <= 5'h00;
      cyc(8);
      chk("os active", {31'h0, timer_output_pin[2]}, 32'h0);
      rdr(`TMR_CNT_BASE + 8'h08);
      chk("os running", {31'h0, rd < 32'h64}, 32'h1);
      wr(`TMR_START_OFS, 32'h0);
      cyc(3);
      chk("os stop out", {31'h0, timer_output_pin[2]}, 32'h1);
      rdr(`TMR_FLAG_OFS);
      chk("os stop flag", rd, 32'h0000_0004);
      rdr(`TMR_CNT_BASE + 8'h08);
      chk("os reload", rd, 32'h0000_0064);
      endt("oneshot");
      wr(`TMR_CUT_OFS, 32'h0000_0001);
      shut_low <= 1'b1;
      cyc(8);
      chk("cut oe", {27'h0, timer_output_pin_oe}, 32'h09);
      chk("cut hiz", {31'h0, phase_input_hiz}, 32'h1);
      chk("cut pins", {27'h0, pin_lvl}, 32'h1A);
      shut_low <= 1'b0;
      cyc(8);
      chk("free oe", {27'h0, timer_output_pin_oe}, 32'h1F);
      chk("free hiz", {31'h0, phase_input_hiz}, 32'h0);
      endt("cutoff");
      finish_test();
   end
endmodule : test_multimode_timer_a_unit
`default_nettype wire
